// ===== rcf_pkg.sv
// Constants, types and helper functions shared by the redundant clock failover generator.
// Assumes a single 125 MHz system clock that samples every board pin through synchronisers.
// Overview of operation
// (R01) Bank A runs at the selected reference times one, two, three, four or eight.
// (R02) Six bank A outputs and six bank B outputs, twelve clocks in all.
// (R03) Bank B runs at the bank A rate or half of it.
// (R04) Banks rise together and track the reference through the external feedback.
// (R05) The board loops the feedback output straight back into the feedback input.
// (R06) Each reference input is watched and reports failure on its own flag.
// (R07) In automatic mode a failed reference is swapped out, with the rate slewing gradually.
// (R08) Both inputs are treated alike, so switching back to a recovered input works.
// (R09) Manual mode changes the reference only when the user changes the select.
// (R10) Bypass mode stops automatic failover and passes the reference through statically.
// (R11) Output disable tristates the banks and resets the internal circuitry.
// (R12) The board applies output disable at power-up.
// (R13) Flag clear resets both failure flags and restores the reference selection.
// (R14) An indicator output shows which reference input is in use.
// (R15) The primary select input picks which reference is the primary source.
// (R16) A four-bit frequency select sets multiplication ratio and bank B divider mode.
// (R17) Low flag clear sets both flags high and copies primary select, once.
// (R18) Low bypass select enables the multiplier; failover works only while enabled.
// (R19) High switch mode selects automatic failover; flags stay live in both modes.
// (R20) The board holds output disable longer than two reference periods.
// (R21) A reference fails when no edge comes within a window of feedback periods.
`default_nettype none

package rcf_pkg;

   localparam int unsigned PER_W = 16;
   localparam int unsigned WIN_W = 8;

   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] RCF_STATUS_OFS = 8'h00;
   localparam logic [7:0] RCF_CTRL_OFS   = 8'h04;
   localparam logic [7:0] RCF_WINDOW_OFS = 8'h08;

   // Field positions.
   localparam int unsigned ST_FAIL_A_BIT = 0;
   localparam int unsigned ST_FAIL_B_BIT = 1;
   localparam int unsigned ST_SEL_BIT    = 2;
   localparam int unsigned ST_BYPASS_BIT = 3;
   localparam int unsigned ST_AUTO_BIT   = 4;
   localparam int unsigned ST_HALF_BIT   = 5;
   localparam int unsigned CTRL_CLR_BIT  = 0;

   // Values after reset, and the shortest period accepted.
   localparam logic [WIN_W-1:0] WINDOW_RST = 8'h04;
   localparam logic [PER_W-1:0] PERIOD_RST = 16'h0100;
   localparam logic [PER_W-1:0] PERIOD_MIN = 16'h0010;

   // Frequency select: bit 3 halves bank B, bits 2:0 pick the multiplier.
   localparam int unsigned FSEL_HALF_BIT = 3;
   localparam logic [2:0] FSEL_M8 = 3'h0;
   localparam logic [2:0] FSEL_M4 = 3'h1;
   localparam logic [2:0] FSEL_M3 = 3'h2;
   localparam logic [2:0] FSEL_M2 = 3'h3;

   typedef struct packed {
      logic [3:0] mult;
      logic       b_half;
   } rcf_ratio_s;

   typedef struct packed {
      logic bank_half;
      logic auto_mode;
      logic bypass;
      logic active_sel;
      logic fail_b;
      logic fail_a;
   } rcf_status_s;

   function automatic rcf_ratio_s rcf_decode(input logic [3:0] fsel);
      rcf_ratio_s r;
      r.b_half = fsel[FSEL_HALF_BIT];
      case (fsel[2:0])
         FSEL_M8: r.mult = 4'h8;
         FSEL_M4: r.mult = 4'h4;
         FSEL_M3: r.mult = 4'h3;
         FSEL_M2: r.mult = 4'h2;
         default: r.mult = 4'h1;
      endcase
      return r;
   endfunction

endpackage : rcf_pkg

`default_nettype wire

// ===== rcf_ref_monitor.sv
// One reference input watchdog with its own pin synchroniser.
// Assumes fb_rise is a one-cycle pulse in the mclk domain per feedback rising edge.
`default_nettype none

module rcf_ref_monitor #(
   parameter int unsigned WIN_W = 8
) (
   input  wire logic             mclk,
   input  wire logic             core_rst,
   input  wire logic             ref_raw,
   input  wire logic             fb_rise,
   input  wire logic [WIN_W-1:0] window,
   input  wire logic             clear,
   output logic                  ref_lvl,
   output logic                  ref_rise,
   output logic                  fail
);
   logic             s1_q;
   logic             s2_q;
   logic             s3_q;
   logic [WIN_W-1:0] cnt_q;
   logic             fail_q;
   logic             timeout;

   always_ff @(posedge mclk) begin
      s1_q <= ref_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   assign ref_lvl  = s2_q;
   assign ref_rise = s2_q & ~s3_q;
   assign timeout  = fb_rise && (cnt_q + 1'b1 >= window);

   // Counts feedback edges since the last reference edge.
   always_ff @(posedge mclk) begin
      if (core_rst || clear || ref_rise) begin
         cnt_q <= '0;
      end else if (fb_rise && cnt_q != '1) begin // R21
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // A timeout in the same cycle as a clear still sets the flag.
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         fail_q <= 1'b0;
      end else if (timeout && !ref_rise) begin
         fail_q <= 1'b1; // R06 R21
      end else if (clear) begin
         fail_q <= 1'b0; // R13
      end
   end

   assign fail = fail_q;
endmodule // rcf_ref_monitor

`default_nettype wire

// ===== rcf_clock_gen.sv
// Top of the redundant clock failover generator: reference selection, digital
// multiplier, output banks, failure flags and a small AHB-Lite register slave.
// Assumes board pins are asynchronous to mclk and feedback_out is looped to feedback_in.
`default_nettype none

module rcf_clock_gen
   import rcf_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  ref_input_a,
   input  wire logic                  ref_input_b,
   input  wire logic                  feedback_in,
   input  wire logic                  primary_select,
   input  wire logic                  switch_mode_select,
   input  wire logic                  flag_clear_n,
   input  wire logic                  pll_bypass_select,
   input  wire logic [3:0]            freq_select,
   input  wire logic                  output_disable_reset,
   output logic [5:0]                 bank_a_out,
   output logic [5:0]                 bank_b_out,
   output logic                       bank_oe,
   output logic                       feedback_out,
   output logic                       ref_a_fail_flag_n,
   output logic                       ref_b_fail_flag_n,
   output logic                       active_ref_indicator,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata
);
   import rcf_pkg::*;

   // Pin synchronisers: logic reads the second stage; clear and feedback also read a third stage for edge detection.
   logic       odr_s1_q, odr_s2_q;
   logic       clr_s1_q, clr_s2_q, clr_s3_q;
   logic       fb_s1_q, fb_s2_q, fb_s3_q;
   logic       prim_s1_q, prim_s2_q;
   logic       auto_s1_q, auto_s2_q;
   logic       byp_s1_q, byp_s2_q;
   logic [3:0] fsel_s1_q, fsel_s2_q;

   always_ff @(posedge mclk) begin
      odr_s1_q  <= output_disable_reset;
      odr_s2_q  <= odr_s1_q;
      clr_s1_q  <= flag_clear_n;
      clr_s2_q  <= clr_s1_q;
      clr_s3_q  <= clr_s2_q;
      fb_s1_q   <= feedback_in;
      fb_s2_q   <= fb_s1_q;
      fb_s3_q   <= fb_s2_q;
      prim_s1_q <= primary_select;
      prim_s2_q <= prim_s1_q;
      auto_s1_q <= switch_mode_select;
      auto_s2_q <= auto_s1_q;
      byp_s1_q  <= pll_bypass_select;
      byp_s2_q  <= byp_s1_q;
      fsel_s1_q <= freq_select;
      fsel_s2_q <= fsel_s1_q;
   end

   logic             core_rst;
   logic             fb_rise;
   logic             clear_shot;
   logic             soft_clear_q;
   logic [WIN_W-1:0] window_q;
   rcf_ratio_s       ratio;
   logic             auto_en;

   assign core_rst   = ~rst_n | odr_s2_q;                  // R11
   assign fb_rise    = fb_s2_q & ~fb_s3_q;
   assign clear_shot = (~clr_s2_q & clr_s3_q) | soft_clear_q; // R17
   assign ratio      = rcf_decode(fsel_s2_q);              // R16
   assign auto_en    = auto_s2_q & ~byp_s2_q;              // R18 R19

   logic lvl_a, lvl_b, rise_a, rise_b, fail_a, fail_b;

   rcf_ref_monitor #(.WIN_W(WIN_W)) u_mon_a (
      .mclk     (mclk),
      .core_rst (core_rst),
      .ref_raw  (ref_input_a),
      .fb_rise  (fb_rise),
      .window   (window_q),
      .clear    (clear_shot),
      .ref_lvl  (lvl_a),
      .ref_rise (rise_a),
      .fail     (fail_a)
   );

   rcf_ref_monitor #(.WIN_W(WIN_W)) u_mon_b (
      .mclk     (mclk),
      .core_rst (core_rst),
      .ref_raw  (ref_input_b),
      .fb_rise  (fb_rise),
      .window   (window_q),
      .clear    (clear_shot),
      .ref_lvl  (lvl_b),
      .ref_rise (rise_b),
      .fail     (fail_b)
   );

   // Reference selection; both inputs are handled by the same symmetric test.
   logic sel_q;
   logic cur_fail;
   logic oth_fail;

   assign cur_fail = sel_q ? fail_b : fail_a;
   assign oth_fail = sel_q ? fail_a : fail_b;

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         sel_q <= 1'b0;
      end else if (clear_shot) begin
         sel_q <= prim_s2_q;                    // R13 R17
      end else if (!auto_en) begin
         sel_q <= prim_s2_q;                    // R09 R10 R15
      end else if (cur_fail && !oth_fail) begin
         sel_q <= ~sel_q;                       // R07 R08 R19
      end
   end

   logic sel_lvl;
   logic sel_rise;
   assign sel_lvl  = sel_q ? lvl_b : lvl_a;
   assign sel_rise = sel_q ? rise_b : rise_a;

   // Reference period estimate. It moves a quarter of the error per edge, so a
   // changeover between inputs slews the rate instead of stepping it.
   logic [PER_W-1:0] meas_q;
   logic [PER_W-1:0] per_q;
   logic             per_valid_q;
   logic [PER_W:0]   per_diff;

   assign per_diff = {1'b0, meas_q} - {1'b0, per_q};

   always_ff @(posedge mclk) begin
      if (core_rst || sel_rise) begin
         meas_q <= '0;
      end else if (meas_q != '1) begin
         meas_q <= meas_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         per_q       <= PERIOD_RST;
         per_valid_q <= 1'b0;
      end else if (sel_rise && meas_q >= PERIOD_MIN) begin
         per_valid_q <= 1'b1;
         if (!per_valid_q) begin
            per_q <= meas_q;
         end else begin
            per_q <= per_q + {{2{per_diff[PER_W]}}, per_diff[PER_W-1:2]}; // R07
         end
      end
   end

   // Phase correction from the external feedback: one count per feedback edge.
   logic [PER_W-1:0] since_q;
   logic [1:0]       nudge_q;

   always_ff @(posedge mclk) begin
      if (core_rst || sel_rise) begin
         since_q <= '0;
      end else if (since_q != '1) begin
         since_q <= since_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (core_rst || !fb_rise || since_q == '0) begin
         nudge_q <= 2'h0;
      end else if (since_q < {1'b0, per_q[PER_W-1:1]}) begin
         nudge_q <= 2'h1;                        // R04
      end else begin
         nudge_q <= 2'h2;                        // R04
      end
   end

   // Fractional divider: 2*mult steps per period estimate gives 2*mult toggles
   // per reference period on bank A.
   logic [PER_W:0]   acc_q;
   logic [PER_W:0]   acc_sum;
   logic [5:0]       step;
   logic             tick;
   logic             a_q;
   logic             b_q;
   logic             fb_q;
   logic [3:0]       fbcnt_q;

   always_comb begin
      step = {1'b0, ratio.mult, 1'b0};
      if (nudge_q == 2'h1) begin
         step = step + 6'h01;
      end else if (nudge_q == 2'h2) begin
         step = step - 6'h01;
      end
   end

   assign acc_sum = acc_q + {{(PER_W-5){1'b0}}, step};
   assign tick    = acc_sum >= {1'b0, per_q};

   always_ff @(posedge mclk) begin
      if (core_rst || byp_s2_q) begin
         acc_q <= '0;
      end else if (tick) begin
         acc_q <= acc_sum - {1'b0, per_q};        // R01
      end else begin
         acc_q <= acc_sum;
      end
   end

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         a_q     <= 1'b0;
         b_q     <= 1'b0;
         fb_q    <= 1'b0;
         fbcnt_q <= '0;
      end else if (byp_s2_q) begin
         // Static pass-through of the selected reference for low-rate test.
         a_q     <= sel_lvl;                     // R10
         fb_q    <= sel_lvl;
         fbcnt_q <= '0;
         // On entry to bypass bank A may already be high; bank B must not rise alone.
         if (sel_rise && !a_q) begin
            b_q <= ratio.b_half ? ~b_q : 1'b1;   // R03
         end else if (!ratio.b_half && !sel_lvl) begin
            b_q <= 1'b0;
         end
      end else if (tick) begin
         a_q <= ~a_q;                            // R01
         // Bank B only toggles on bank A rising edges in half mode.
         if (!ratio.b_half) begin
            b_q <= ~a_q;                         // R03 R04
         end else if (!a_q) begin
            b_q <= ~b_q;                         // R03 R04
         end
         if (fbcnt_q + 4'h1 >= ratio.mult) begin
            fbcnt_q <= '0;
            fb_q    <= ~fb_q;                    // R04
         end else begin
            fbcnt_q <= fbcnt_q + 4'h1;
         end
      end
   end

   // Output flops; the feedback output stays driven under output disable.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bank_a_out   <= '0;
         bank_b_out   <= '0;
         bank_oe      <= 1'b0;
         feedback_out <= 1'b0;
      end else begin
         bank_a_out   <= {6{a_q}};               // R02
         bank_b_out   <= {6{b_q}};               // R02
         bank_oe      <= ~odr_s2_q;              // R11
         feedback_out <= fb_q;
      end
   end

   // Flags read high when the input is healthy, as after a clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_a_fail_flag_n    <= 1'b1;
         ref_b_fail_flag_n    <= 1'b1;
         active_ref_indicator <= 1'b0;
      end else begin
         ref_a_fail_flag_n    <= ~fail_a;        // R06
         ref_b_fail_flag_n    <= ~fail_b;        // R06
         active_ref_indicator <= sel_q;          // R14
      end
   end

   // AHB-Lite slave, zero wait states, always OKAY.
   rcf_status_s status;
   logic        ap_valid;
   logic        dp_wr_q;
   logic [7:0]  dp_addr_q;

   assign status = '{bank_half: ratio.b_half, auto_mode: auto_en, bypass: byp_s2_q,
                     active_sel: sel_q, fail_b: fail_b, fail_a: fail_a};
   assign ap_valid = hsel & htrans[1] & hready;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_wr_q   <= ap_valid & hwrite;
         dp_addr_q <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (ap_valid && !hwrite) begin
         if (haddr[7:0] == RCF_STATUS_OFS) begin
            hrdata <= {26'h0, status};
         end else if (haddr[7:0] == RCF_WINDOW_OFS) begin
            hrdata <= {24'h000000, window_q};
         end else begin
            hrdata <= '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         window_q     <= WINDOW_RST;
         soft_clear_q <= 1'b0;
      end else begin
         soft_clear_q <= 1'b0;
         if (dp_wr_q && dp_addr_q == RCF_CTRL_OFS) begin
            soft_clear_q <= hwdata[CTRL_CLR_BIT]; // R13
         end else if (dp_wr_q && dp_addr_q == RCF_WINDOW_OFS && hwdata[7:0] != 8'h00) begin
            window_q <= hwdata[7:0];             // R21
         end
      end
   end

endmodule // rcf_clock_gen

`default_nettype wire

// ===== rcf_props.sv
// Concurrent checks on the ports of the clock failover generator top.
// Assumes one mclk domain and a synchronous active-low rst_n.
`default_nettype none

module rcf_props (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       primary_select,
   input wire logic       switch_mode_select,
   input wire logic       flag_clear_n,
   input wire logic       pll_bypass_select,
   input wire logic       output_disable_reset,
   input wire logic [5:0] bank_a_out,
   input wire logic [5:0] bank_b_out,
   input wire logic       bank_oe,
   input wire logic       ref_a_fail_flag_n,
   input wire logic       ref_b_fail_flag_n,
   input wire logic       active_ref_indicator,
   input wire logic       hreadyout,
   input wire logic       hresp
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or answered with an error");
   oe_off_a: assert property (output_disable_reset [*5] |-> !bank_oe)
      else $error("banks still driven under output disable");
   flags_idle_a: assert property (output_disable_reset [*5] |-> ref_a_fail_flag_n && ref_b_fail_flag_n)
      else $error("fail flag set under output disable");
   bank_equal_a: assert property (bank_a_out == {6{bank_a_out[0]}} && bank_b_out == {6{bank_b_out[0]}})
      else $error("outputs within a bank differ");
   bank_align_a: assert property ($rose(bank_b_out[0]) |-> $rose(bank_a_out[0]))
      else $error("bank B rose without bank A");
   flag_sticky_a: assert property ($fell(ref_a_fail_flag_n) && flag_clear_n && !output_disable_reset
      |=> !ref_a_fail_flag_n [*3])
      else $error("fail flag A did not stay set");
   manual_follow_a: assert property ((!switch_mode_select && !output_disable_reset && primary_select) [*8]
      |-> active_ref_indicator)
      else $error("manual mode left the chosen reference");
   bypass_static_a: assert property ((pll_bypass_select && !output_disable_reset && !primary_select) [*8]
      |-> !active_ref_indicator)
      else $error("bypass mode changed reference on its own");
   auto_to_b_a: assert property ($fell(ref_a_fail_flag_n) && switch_mode_select && !pll_bypass_select
      && ref_b_fail_flag_n && !active_ref_indicator |-> ##[0:4] active_ref_indicator)
      else $error("no changeover from failed input A");
   auto_to_a_a: assert property ($fell(ref_b_fail_flag_n) && switch_mode_select && !pll_bypass_select
      && ref_a_fail_flag_n && active_ref_indicator |-> ##[0:4] !active_ref_indicator)
      else $error("no changeover back to recovered input A");
   clear_restore_a: assert property ($fell(flag_clear_n) |-> ##[2:6] (ref_a_fail_flag_n
      && ref_b_fail_flag_n && active_ref_indicator == primary_select))
      else $error("flag clear did not restore flags and selection");

   cover property ($fell(ref_a_fail_flag_n));
   cover property ($fell(flag_clear_n));
   cover property (pll_bypass_select && $rose(bank_a_out[0]));
endmodule // rcf_props

bind rcf_clock_gen rcf_props u_props (
   .mclk(mclk), .rst_n(rst_n), .primary_select(primary_select),
   .switch_mode_select(switch_mode_select), .flag_clear_n(flag_clear_n),
   .pll_bypass_select(pll_bypass_select), .output_disable_reset(output_disable_reset),
   .bank_a_out(bank_a_out), .bank_b_out(bank_b_out), .bank_oe(bank_oe),
   .ref_a_fail_flag_n(ref_a_fail_flag_n), .ref_b_fail_flag_n(ref_b_fail_flag_n),
   .active_ref_indicator(active_ref_indicator), .hreadyout(hreadyout), .hresp(hresp)
);

`default_nettype wire

// ===== rcf_board_model.sv
// Board side of the generator: two redundant reference oscillators and the feedback loop.
// Assumes the bench starts and stops each oscillator through run_a and run_b.
`default_nettype none

module rcf_board_model #(
   parameter int HALF_NS = 256
) (
   input  wire logic run_a,
   input  wire logic run_b,
   input  wire logic feedback_out,
   output logic      ref_input_a,
   output logic      ref_input_b,
   output logic      feedback_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // A dead oscillator parks low, as a lost source does on the board.
   initial begin
      ref_input_a = 1'b0;
      forever #(HALF_NS) ref_input_a = run_a ? ~ref_input_a : 1'b0;
   end

   // Source B is offset so the two inputs are never in phase.
   initial begin
      ref_input_b = 1'b0;
      #(HALF_NS / 3);
      forever #(HALF_NS) ref_input_b = run_b ? ~ref_input_b : 1'b0;
   end

   assign feedback_in = feedback_out;
endmodule // rcf_board_model

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the clock failover generator and its register slave.
// Assumes the board model loops feedback and each reference period is 64 mclk cycles.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import rcf_pkg::*;

   typedef struct {logic byp; logic [3:0] fsel; int a; int b;} rcf_row_s;

   logic        mclk = 1'b0, rst_n = 1'b0, run_a = 1'b1, run_b = 1'b1;
   logic        ref_input_a, ref_input_b, feedback_in, feedback_out;
   logic        primary_select = 1'b0, switch_mode_select = 1'b1, flag_clear_n = 1'b1;
   logic        pll_bypass_select = 1'b0, output_disable_reset = 1'b1;
   logic [3:0]  freq_select = 4'h4;
   logic [5:0]  bank_a_out, bank_b_out;
   logic        bank_oe, ref_a_fail_flag_n, ref_b_fail_flag_n, active_ref_indicator;
   logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   int          fail_count = 0, n_tests = 0, cyc = 0, a_rise = 0, b_rise = 0, a0, b0, f0;
   int          f_rise = 0;
   logic        a_prev = 1'b0, b_prev = 1'b0, f_prev = 1'b0;
   rcf_row_s    rows [10] = '{'{0, 4'h0, 64, 64}, '{0, 4'h8, 64, 32}, '{0, 4'h1, 32, 32},
      '{0, 4'h2, 24, 24}, '{0, 4'ha, 24, 12}, '{0, 4'h3, 16, 16}, '{0, 4'h4, 8, 8},
      '{0, 4'hc, 8, 4}, '{1, 4'h0, 8, 8}, '{1, 4'h8, 8, 4}};

   initial begin
      forever #4 mclk = ~mclk;
   end

   rcf_board_model u_board (.run_a(run_a), .run_b(run_b), .feedback_out(feedback_out),
      .ref_input_a(ref_input_a), .ref_input_b(ref_input_b), .feedback_in(feedback_in));

   rcf_clock_gen dut (.mclk(mclk), .rst_n(rst_n), .ref_input_a(ref_input_a),
      .ref_input_b(ref_input_b), .feedback_in(feedback_in), .primary_select(primary_select),
      .switch_mode_select(switch_mode_select), .flag_clear_n(flag_clear_n),
      .pll_bypass_select(pll_bypass_select), .freq_select(freq_select),
      .output_disable_reset(output_disable_reset), .bank_a_out(bank_a_out),
      .bank_b_out(bank_b_out), .bank_oe(bank_oe), .feedback_out(feedback_out),
      .ref_a_fail_flag_n(ref_a_fail_flag_n), .ref_b_fail_flag_n(ref_b_fail_flag_n),
      .active_ref_indicator(active_ref_indicator), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   always @(posedge mclk) begin
      a_prev <= bank_a_out[0];
      b_prev <= bank_b_out[0];
      f_prev <= feedback_out;
      if (feedback_out && !f_prev) f_rise <= f_rise + 1;
      if (bank_a_out[0] && !a_prev) a_rise <= a_rise + 1;
      if (bank_b_out[0] && !b_prev) b_rise <= b_rise + 1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One single transfer; the address phase is held until the slave shows ready.
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic wait_low(input logic b);
      int n;
      n = 0;
      while (n < 3000 && (b ? ref_b_fail_flag_n : ref_a_fail_flag_n) !== 1'b0) begin
         n++;
         @(posedge mclk);
      end
   endtask

   task automatic pulse_clear();
      flag_clear_n <= 1'b0;
      repeat (4) @(posedge mclk);
      flag_clear_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      check({bank_oe, ref_a_fail_flag_n, ref_b_fail_flag_n, hreadyout}, 32'h7);
      rst_n <= 1'b1;
      repeat (200) @(posedge mclk);
      output_disable_reset <= 1'b0;
      repeat (2048) @(posedge mclk);
      check(bank_oe, 1'b1);
      ahb({24'h0, RCF_STATUS_OFS}, 1'b0, 32'h0);
      check(rd, 32'h10);
      ahb({24'h0, RCF_WINDOW_OFS}, 1'b1, 32'h6);
      ahb({24'h0, RCF_WINDOW_OFS}, 1'b1, 32'h0);
      ahb({24'h0, RCF_WINDOW_OFS}, 1'b0, 32'h0);
      check(rd, 32'h6);
      ahb(32'h0000_000c, 1'b0, 32'h0);
      check(rd, 32'h0);
      foreach (rows[i]) begin
         pll_bypass_select <= rows[i].byp;
         freq_select <= rows[i].fsel;
         repeat (1024) @(posedge mclk);
         a0 = a_rise;
         b0 = b_rise;
         f0 = f_rise;
         repeat (512) @(posedge mclk);
         check(32'(f_rise - f0 >= 6 && f_rise - f0 <= 10), 32'h1);
         check(32'(a_rise - a0 >= rows[i].a - 2 && a_rise - a0 <= rows[i].a + 2), 32'h1);
         check(32'(b_rise - b0 >= rows[i].b - 2 && b_rise - b0 <= rows[i].b + 2), 32'h1);
      end
      pll_bypass_select <= 1'b0;
      freq_select <= 4'h4;
      repeat (1024) @(posedge mclk);
      run_a <= 1'b0;
      wait_low(1'b0);
      repeat (8) @(posedge mclk);
      check({ref_a_fail_flag_n, ref_b_fail_flag_n, active_ref_indicator}, 32'h3);
      ahb({24'h0, RCF_STATUS_OFS}, 1'b0, 32'h0);
      check(rd, 32'h15);
      primary_select <= 1'b1;
      run_a <= 1'b1;
      repeat (300) @(posedge mclk);
      pulse_clear();
      check({ref_a_fail_flag_n, ref_b_fail_flag_n, active_ref_indicator}, 32'h7);
      run_b <= 1'b0;
      wait_low(1'b1);
      repeat (8) @(posedge mclk);
      check({ref_a_fail_flag_n, ref_b_fail_flag_n, active_ref_indicator}, 32'h4);
      run_b <= 1'b1;
      repeat (300) @(posedge mclk);
      ahb({24'h0, RCF_CTRL_OFS}, 1'b1, 32'h1);
      repeat (8) @(posedge mclk);
      check({ref_b_fail_flag_n, active_ref_indicator}, 32'h3);
      switch_mode_select <= 1'b0;
      run_b <= 1'b0;
      wait_low(1'b1);
      repeat (8) @(posedge mclk);
      check({ref_b_fail_flag_n, active_ref_indicator}, 32'h1);
      primary_select <= 1'b0;
      repeat (8) @(posedge mclk);
      check(active_ref_indicator, 1'b0);
      run_b <= 1'b1;
      output_disable_reset <= 1'b1;
      repeat (200) @(posedge mclk);
      check({bank_oe, ref_a_fail_flag_n, ref_b_fail_flag_n}, 32'h3);
      output_disable_reset <= 1'b0;
      repeat (200) @(posedge mclk);
      check(bank_oe, 1'b1);
      finish_test();
   end
endmodule // testbench

`default_nettype wire
